// file: hdl/ds3_rx_error_counters.sv
// Receive framing and parity error counter bank with register port and interrupt
//
// The plain strobed port is this design's own decision.
module ds3_rx_error_counters
   import err_count_pkg::*;
#(
   parameter int WIDTH = COUNT_W
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Error events from the receive framer
   input wire err_ev_t err_ev,
   // Performance-monitoring update
   input wire logic counter_update_strobe,
   // Register port
   input wire reg_req_t req,
   output logic [DATA_W-1:0] rd_data_r,
   // Interrupt
   output logic irq_r
);
   generate
      if (WIDTH < 1 || WIDTH > DATA_W)
      begin : g_bad_width
         $error("Counter width must be 1 to 16");
      end
   endgenerate

   logic ctrl_en_r;
   logic [STAT_W-1:0] mask_r;
   logic [STAT_W-1:0] status_r;
   logic [STAT_W-1:0] status_nxt;
   logic [WIDTH-1:0] frm_vis;
   logic [WIDTH-1:0] frm_hid;
   logic [WIDTH-1:0] par_vis;
   logic [WIDTH-1:0] par_hid;
   logic frm_lost;
   logic par_lost;

   // Address decode
   wire sel_frm = (req.addr == ADDR_FRM_COUNT);
   wire sel_par = (req.addr == ADDR_PAR_COUNT);
   wire sel_st = (req.addr == ADDR_STATUS);
   wire sel_mask = (req.addr == ADDR_MASK);
   wire sel_ctrl = (req.addr == ADDR_CTRL);

   wire wr_st = req.wr & sel_st;
   wire wr_mask = req.wr & sel_mask;
   wire wr_ctrl = req.wr & sel_ctrl;

   // Software may force an update for testing; it acts exactly like the strobe
   wire sw_update = wr_ctrl & req.wdata[CTRL_SWUPD_BIT];
   wire update = counter_update_strobe | sw_update;
   wire count_en = ctrl_en_r;

   // Tallies
   tally_counter #(.WIDTH(WIDTH)) u_framing
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .count_en(count_en),
      .err_pulse(err_ev.framing),
      .update(update),
      .visible_r(frm_vis),
      .hidden_r(frm_hid),
      .lost(frm_lost)
   );

   tally_counter #(.WIDTH(WIDTH)) u_parity
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .count_en(count_en),
      .err_pulse(err_ev.parity),
      .update(update),
      .visible_r(par_vis),
      .hidden_r(par_hid),
      .lost(par_lost)
   );

   // Events: a nonzero interval was published, or an error fell on a full counter
   wire [STAT_W-1:0] status_set;
   assign status_set[ST_FRM_NZ] = update & (frm_hid != '0);
   assign status_set[ST_PAR_NZ] = update & (par_hid != '0);
   assign status_set[ST_FRM_LOST] = frm_lost;
   assign status_set[ST_PAR_LOST] = par_lost;

   // Write one to clear; a set in the same cycle wins
   wire [STAT_W-1:0] status_clr = wr_st ? req.wdata[STAT_W-1:0] : '0;
   assign status_nxt = (status_r & ~status_clr) | status_set;

   // Read mux; unmapped addresses read zero
   wire [DATA_W-1:0] rd_mux =
      sel_frm ? DATA_W'(frm_vis) :
      sel_par ? DATA_W'(par_vis) :
      sel_st ? DATA_W'(status_r) :
      sel_mask ? DATA_W'(mask_r) :
      sel_ctrl ? DATA_W'(ctrl_en_r) :
      '0;

   wire irq_nxt = |(status_nxt & mask_r);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_en_r <= CTRL_RESET[CTRL_EN_BIT];
         mask_r <= MASK_RESET;
         status_r <= STATUS_RESET;
      end
      else
      begin
         if (wr_ctrl)
         begin
            // The update bit is a pulse and is never stored, so it reads zero
            ctrl_en_r <= req.wdata[CTRL_EN_BIT];
         end
         if (wr_mask)
         begin
            mask_r <= req.wdata[STAT_W-1:0];
         end
         status_r <= status_nxt;
      end
   end

   // Read data stand only in the cycle after the read strobe
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_data_r <= '0;
         irq_r <= 1'b0;
      end
      else
      begin
         rd_data_r <= req.rd ? rd_mux : '0;
         irq_r <= irq_nxt;
      end
   end

   localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};

   a_frm_accumulate:
   assert property (@(posedge ref_clk) disable iff (rst)
      (count_en && err_ev.framing && !update && frm_hid != MAX_COUNT)
      |=> frm_hid == WIDTH'($past(frm_hid) + 1'b1))
   else
      $error("Framing hidden count did not advance by one");

   a_frm_quiet_hold:
   assert property (@(posedge ref_clk) disable iff (rst)
      (!err_ev.framing && !update) |=> $stable(frm_hid))
   else
      $error("Framing hidden count moved without an error");

   a_frm_visible_hold:
   assert property (@(posedge ref_clk) disable iff (rst)
      !update |=> $stable(frm_vis))
   else
      $error("Framing count changed without an update");

   a_par_accumulate:
   assert property (@(posedge ref_clk) disable iff (rst)
      (count_en && err_ev.parity && !update && par_hid != MAX_COUNT)
      |=> par_hid == WIDTH'($past(par_hid) + 1'b1))
   else
      $error("Parity hidden count did not advance by one");

   a_par_visible_hold:
   assert property (@(posedge ref_clk) disable iff (rst)
      !update |=> $stable(par_vis))
   else
      $error("Parity count changed without an update");

   a_update_transfer:
   assert property (@(posedge ref_clk) disable iff (rst)
      update |=> (frm_vis == $past(frm_hid)) && (par_vis == $past(par_hid)))
   else
      $error("Update did not copy hidden counts");

   a_update_restart:
   assert property (@(posedge ref_clk) disable iff (rst)
      update |=> frm_hid == WIDTH'($past(count_en && err_ev.framing)))
   else
      $error("Hidden framing count did not restart after update");

   a_count_saturate:
   assert property (@(posedge ref_clk) disable iff (rst)
      (frm_hid == MAX_COUNT && !update) |=> frm_hid == MAX_COUNT)
   else
      $error("Framing hidden count wrapped");

   a_read_framing:
   assert property (@(posedge ref_clk) disable iff (rst)
      (req.rd && sel_frm) |=> rd_data_r == DATA_W'($past(frm_vis)))
   else
      $error("Framing count read returned wrong data");

   a_read_parity:
   assert property (@(posedge ref_clk) disable iff (rst)
      (req.rd && sel_par) |=> rd_data_r == DATA_W'($past(par_vis)))
   else
      $error("Parity count read returned wrong data");

   a_par_quiet_hold:
   assert property (@(posedge ref_clk) disable iff (rst)
      (!err_ev.parity && !update) |=> $stable(par_hid))
   else
      $error("Parity hidden count moved without an error");

   a_par_saturate:
   assert property (@(posedge ref_clk) disable iff (rst)
      (par_hid == MAX_COUNT && !update) |=> par_hid == MAX_COUNT)
   else
      $error("Parity hidden count wrapped");

   a_par_restart:
   assert property (@(posedge ref_clk) disable iff (rst)
      update |=> par_hid == WIDTH'($past(count_en && err_ev.parity)))
   else
      $error("Hidden parity count did not restart after update");

   a_count_disabled:
   assert property (@(posedge ref_clk) disable iff (rst)
      (!count_en && !update) |=> $stable(frm_hid) && $stable(par_hid))
   else
      $error("Hidden count moved while counting was disabled");

   // Status, mask and read-back of the status register
   a_lost_flag:
   assert property (@(posedge ref_clk) disable iff (rst)
      (count_en && err_ev.framing && !update && frm_hid == MAX_COUNT)
      |=> status_r[ST_FRM_LOST])
   else
      $error("Framing error on a full counter was not flagged");

   a_status_clear:
   assert property (@(posedge ref_clk) disable iff (rst)
      (wr_st && req.wdata[ST_FRM_NZ] && !update) |=> !status_r[ST_FRM_NZ])
   else
      $error("Framing status bit did not clear on write one");

   a_status_sticky:
   assert property (@(posedge ref_clk) disable iff (rst)
      (status_r[ST_PAR_NZ] && !wr_st) |=> status_r[ST_PAR_NZ])
   else
      $error("Parity status bit dropped without a clear");

   a_par_status_set:
   assert property (@(posedge ref_clk) disable iff (rst)
      (update && par_hid != '0) |=> status_r[ST_PAR_NZ])
   else
      $error("Parity status bit lost on update");

   a_mask_write:
   assert property (@(posedge ref_clk) disable iff (rst)
      (req.wr && sel_mask) |=> mask_r == $past(req.wdata[STAT_W-1:0]))
   else
      $error("Mask write did not land");

   a_read_status:
   assert property (@(posedge ref_clk) disable iff (rst)
      (req.rd && sel_st) |=> rd_data_r == DATA_W'($past(status_r)))
   else
      $error("Status read returned wrong data");

   a_read_idle_zero:
   assert property (@(posedge ref_clk) disable iff (rst)
      !req.rd |=> rd_data_r == '0)
   else
      $error("Read data present without a read");

   a_irq_level:
   assert property (@(posedge ref_clk) disable iff (rst)
      ##1 irq_r == |($past(status_nxt) & $past(mask_r)))
   else
      $error("Interrupt does not follow masked status");

   a_status_set_wins:
   assert property (@(posedge ref_clk) disable iff (rst)
      (update && frm_hid != '0) |=> status_r[ST_FRM_NZ])
   else
      $error("Framing status bit lost on update");

   c_update_nonzero:
   cover property (@(posedge ref_clk) disable iff (rst)
      update && frm_hid != '0 && par_hid != '0);

   c_error_on_update:
   cover property (@(posedge ref_clk) disable iff (rst)
      update && err_ev.framing);

   c_clear_and_set:
   cover property (@(posedge ref_clk) disable iff (rst)
      wr_st && (status_set != '0));

   c_irq_raised:
   cover property (@(posedge ref_clk) disable iff (rst)
      !irq_r ##1 irq_r);

   c_count_saturated:
   cover property (@(posedge ref_clk) disable iff (rst)
      frm_lost);
endmodule

// file: hdl/err_count_pkg.sv
// Shared constants and carrier types for the receive error counter bank
package err_count_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int COUNT_W = 16;
   localparam int STAT_W = 4;

   // Register indices; the byte address is four times the index
   localparam logic [9:0] IDX_FRM_COUNT = 10'h134;
   localparam logic [9:0] IDX_PAR_COUNT = 10'h136;
   localparam logic [9:0] IDX_STATUS = 10'h138;
   localparam logic [9:0] IDX_MASK = 10'h13a;
   localparam logic [9:0] IDX_CTRL = 10'h13c;

   localparam logic [ADDR_W-1:0] ADDR_FRM_COUNT = {IDX_FRM_COUNT, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_PAR_COUNT = {IDX_PAR_COUNT, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};

   // Reset values
   localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [STAT_W-1:0] STATUS_RESET = 4'h0;
   localparam logic [STAT_W-1:0] MASK_RESET = 4'h0;
   localparam logic [1:0] CTRL_RESET = 2'h1;

   // Control fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SWUPD_BIT = 1;

   // Status and mask fields
   localparam int ST_FRM_NZ = 0;
   localparam int ST_PAR_NZ = 1;
   localparam int ST_FRM_LOST = 2;
   localparam int ST_PAR_LOST = 3;

   typedef struct packed
   {
      logic framing;
      logic parity;
   } err_ev_t;

   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage

// file: hdl/tally_counter.sv
// One error tally: hidden accumulator plus the software-visible snapshot
module tally_counter
   import err_count_pkg::*;
#(
   parameter int WIDTH = COUNT_W
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Event side
   input wire logic count_en,
   input wire logic err_pulse,
   input wire logic update,
   // Results
   output logic [WIDTH-1:0] visible_r,
   output logic [WIDTH-1:0] hidden_r,
   output wire logic lost
);
   localparam logic [WIDTH-1:0] FULL = {WIDTH{1'b1}};

   logic [WIDTH-1:0] hidden_nxt;
   wire hit = count_en & err_pulse;
   wire full = (hidden_r == FULL);

   // Saturate rather than wrap so a long interval never reads as a small count
   assign lost = hit & full & ~update;

   // An error in the update cycle opens the new interval instead of being lost
   assign hidden_nxt = update ? {{(WIDTH-1){1'b0}}, hit} :
                       (hit & ~full) ? WIDTH'(hidden_r + 1'b1) : hidden_r;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         hidden_r <= '0;
         visible_r <= WIDTH'(COUNT_RESET);
      end
      else
      begin
         hidden_r <= hidden_nxt;
         if (update)
         begin
            visible_r <= hidden_r;
         end
      end
   end
endmodule

// file: bench/ds3_rx_error_counters_tb.sv
// Self-checking bench for the receive error counter bank
module ds3_rx_error_counters_tb
   import err_count_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   err_ev_t err_ev = '0;
   logic counter_update_strobe = 1'b0;
   reg_req_t req = '0;
   logic [DATA_W-1:0] rd_data_r;
   logic irq_r;
   int error_cnt = 0;
   int n_compared = 0;
   logic [15:0] rd_v;

   ds3_rx_error_counters #(.WIDTH(COUNT_W)) i_dut
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .err_ev(err_ev),
      .counter_update_strobe(counter_update_strobe),
      .req(req),
      .rd_data_r(rd_data_r),
      .irq_r(irq_r)
   );

   always #12.5 ref_clk = ~ref_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      if (error_cnt == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // Read data is taken in the single cycle after the strobe
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1 d = rd_data_r;
   endtask

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask

   task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
      rd_reg(a, rd_v);
      check(rd_v, exp);
   endtask

   // Registered level: look just after the edge, once it has settled
   task automatic expect_irq(input logic exp);
      #1 check({15'h0000, irq_r}, {15'h0000, exp});
   endtask

   // One cycle of events; framing, parity and update may coincide
   task automatic pulse(input logic fr, input logic pa, input logic st);
      @(posedge ref_clk);
      err_ev.framing <= fr;
      err_ev.parity <= pa;
      counter_update_strobe <= st;
      @(posedge ref_clk);
      err_ev <= '0;
      counter_update_strobe <= 1'b0;
   endtask

   task automatic s_reset();
      expect_reg(ADDR_FRM_COUNT, 16'h0000);
      expect_reg(ADDR_PAR_COUNT, 16'h0000);
      expect_reg(ADDR_STATUS, 16'h0000);
      expect_reg(ADDR_MASK, 16'h0000);
      expect_reg(ADDR_CTRL, 16'h0001);
      expect_irq(1'b0);
   endtask

   task automatic s_count();
      pulse(1'b1, 1'b0, 1'b0);
      pulse(1'b1, 1'b1, 1'b0);
      pulse(1'b1, 1'b1, 1'b0);
      expect_reg(ADDR_FRM_COUNT, 16'h0000);
      expect_reg(ADDR_PAR_COUNT, 16'h0000);
      pulse(1'b0, 1'b0, 1'b1);
      expect_reg(ADDR_FRM_COUNT, 16'h0003);
      expect_reg(ADDR_PAR_COUNT, 16'h0002);
      // Count registers are read only; the unmapped hole reads zero
      wr_reg(ADDR_FRM_COUNT, 16'hffff);
      expect_reg(ADDR_FRM_COUNT, 16'h0003);
      expect_reg(12'h4d4, 16'h0000);
      // Error in the update cycle belongs to the new interval
      pulse(1'b1, 1'b0, 1'b1);
      expect_reg(ADDR_FRM_COUNT, 16'h0000);
      pulse(1'b0, 1'b0, 1'b1);
      expect_reg(ADDR_FRM_COUNT, 16'h0001);
      expect_reg(ADDR_PAR_COUNT, 16'h0000);
   endtask

   task automatic s_irq();
      expect_reg(ADDR_STATUS, 16'h0003);
      expect_irq(1'b0);
      wr_reg(ADDR_MASK, 16'h0001);
      idle(2);
      expect_irq(1'b1);
      wr_reg(ADDR_STATUS, 16'h0003);
      idle(2);
      expect_irq(1'b0);
      expect_reg(ADDR_STATUS, 16'h0000);
   endtask

   task automatic s_enable();
      wr_reg(ADDR_CTRL, 16'h0000);
      pulse(1'b1, 1'b1, 1'b0);
      wr_reg(ADDR_CTRL, 16'h0003);
      idle(2);
      expect_reg(ADDR_FRM_COUNT, 16'h0000);
      expect_reg(ADDR_PAR_COUNT, 16'h0000);
      expect_reg(ADDR_CTRL, 16'h0001);
      pulse(1'b0, 1'b1, 1'b0);
      wr_reg(ADDR_CTRL, 16'h0003);
      idle(2);
      expect_reg(ADDR_PAR_COUNT, 16'h0001);
   endtask

   // Errors held high for 65536 cycles fill the counter and lose the last one
   task automatic s_saturate();
      wr_reg(ADDR_STATUS, 16'h000f);
      @(posedge ref_clk);
      err_ev.framing <= 1'b1;
      idle(65536);
      err_ev.framing <= 1'b0;
      wr_reg(ADDR_CTRL, 16'h0003);
      expect_reg(ADDR_FRM_COUNT, 16'hffff);
      expect_reg(ADDR_STATUS, 16'h0005);
      expect_irq(1'b1);
      // A reset in mid-run brings the published count back to zero
      @(posedge ref_clk);
      rst <= 1'b1;
      idle(2);
      rst <= 1'b0;
      idle(2);
      expect_reg(ADDR_FRM_COUNT, 16'h0000);
      expect_reg(ADDR_STATUS, 16'h0000);
      expect_irq(1'b0);
   endtask

   // Fixed-latency port, so a global cycle bound is the only guard needed
   initial
   begin
      idle(90000);
      error_cnt++;
      end_sim();
   end

   initial
   begin
      idle(20);
      rst <= 1'b0;
      idle(2);
      s_reset();
      s_count();
      s_irq();
      s_enable();
      s_saturate();
      idle(4);
      end_sim();
   end
endmodule
